// *** core/clk_ctrl_defs.vh ***
// Constants for the serial control register bank
`ifndef CLK_CTRL_DEFS_VH
`define CLK_CTRL_DEFS_VH
`define SLAVE_ADDR_7       7'h69
`define CMD_BYTE_OP_MASK   3'h4
`define OFS_DIFF_REF_EN    7'h00
`define OFS_SPREAD_MISC_EN 7'h01
`define OFS_PCI_EN         7'h02
`define RST_DIFF_REF_EN    8'hff
`define RST_SPREAD_MISC_EN 8'hfe
`define RST_PCI_EN         8'hff
`define BIT_SPREAD_MODE    7
`define BIT_DOT_EN         6
`define BIT_USB_EN         5
`define BIT_REF_CLOCK_OUT_0_EN        4
`define BIT_REF_CLOCK_OUT_1_EN        3
`define BIT_CPU1_EN        2
`define BIT_CPU0_EN        1
`define BIT_SPREAD_ON      0
`endif

// *** core/clock_output_serial_ctrl_regs.v ***
// Serial slave with control bytes 0..2 for a multi-output clock generator
// Overview of operation
// [RULE1] A byte write is start, address, write bit, ack, command, ack, data, ack, stop.
// [RULE2] A byte command has the form 100xxxxx and its low seven bits pick the control byte.
// [RULE3] A byte read is write phase with command, repeated start, address with read bit, ack, data out, master ack, stop.
// [RULE4] Control byte 0 enables the seven reference pairs and the storage pair, all on at power-up.
// [RULE5] Control byte 1 bit 7 picks centre spread (0) or down spread (1), one at power-up.
// [RULE6] Control byte 1 bit 0 turns spread on, zero at power-up.
// [RULE7] Control byte 1 bits 6, 2 and 1 enable the dot pair and processor pairs 1 and 0.
// [RULE8] Control byte 1 bits 5, 4 and 3 enable the USB output and reference outputs 0 and 1.
// [RULE9] Control byte 2 enables bus clock outputs 5..0 and free bus clock outputs 1..0.
// [RULE10] The slave answers only to address byte 11010010 with its write bit, or 11010011 with its read bit after a command.
// [RULE11] A written byte takes effect only after the data byte is acknowledged.
`timescale 1ns/1ps
`include "clk_ctrl_defs.vh"
module clock_output_serial_ctrl_regs (
   input  wire       sys_clk_in,
   input  wire       rst_n_in,
   input  wire       scl_in,
   input  wire       sda_in,
   output reg        sda_out,
   output reg        sda_oe_out,
   output reg  [7:0] diff_ref_pair_en_out,
   output reg        dot_clock_pair_en_out,
   output reg        usb_clock_en_out,
   output reg        ref_clock_out_0_en_out,
   output reg        ref_clock_out_1_en_out,
   output reg        cpu_pair_1_en_out,
   output reg        cpu_pair_0_en_out,
   output reg        spread_down_mode_out,
   output reg        spread_on_out,
   output reg  [5:0] bus_clock_en_out,
   output reg  [1:0] free_bus_clock_en_out
);
   localparam ST_IDLE  = 7'b0000001;
   localparam ST_ADDR  = 7'b0000010;
   localparam ST_AACK  = 7'b0000100;
   localparam ST_CMD   = 7'b0001000;
   localparam ST_WDATA = 7'b0010000;
   localparam ST_RDATA = 7'b0100000;
   localparam ST_MACK  = 7'b1000000;

   wire       scl_s;
   wire       sda_s;
   wire       scl_rise;
   wire       scl_fall;
   wire       sda_rise;
   wire       sda_fall;
   reg  [6:0] state_q;
   reg  [7:0] shift_q;
   reg  [3:0] bit_cnt_q;
   reg        ack_drive_q;
   reg        after_ack_q;
   reg        cmd_seen_q;
   reg        is_read_q;
   reg  [6:0] offset_q;
   reg        offset_ok_q;
   reg  [7:0] reg0_q;
   reg  [7:0] reg1_q;
   reg  [7:0] reg2_q;
   reg  [7:0] rd_byte;
   reg        wr_pend_q;
   reg  [7:0] wr_data_q;
   wire       start_det;
   wire       stop_det;
   wire [7:0] byte_in;

   pin_sync #(.RST_VAL(1'b1)) u_scl_sync (
      .sys_clk_in (sys_clk_in),
      .rst_n_in   (rst_n_in),
      .async_in   (scl_in),
      .sync_out   (scl_s)
   );
   pin_sync #(.RST_VAL(1'b1)) u_sda_sync (
      .sys_clk_in (sys_clk_in),
      .rst_n_in   (rst_n_in),
      .async_in   (sda_in),
      .sync_out   (sda_s)
   );
   line_edge u_scl_edge (
      .sys_clk_in (sys_clk_in),
      .rst_n_in   (rst_n_in),
      .line_in    (scl_s),
      .rise_out   (scl_rise),
      .fall_out   (scl_fall)
   );
   line_edge u_sda_edge (
      .sys_clk_in (sys_clk_in),
      .rst_n_in   (rst_n_in),
      .line_in    (sda_s),
      .rise_out   (sda_rise),
      .fall_out   (sda_fall)
   );

   // Start and stop: data moves while clock is high
   assign start_det = sda_fall & scl_s;
   assign stop_det  = sda_rise & scl_s;
   assign byte_in   = {shift_q[6:0], sda_s};

   // Readback mux by offset
   always @* begin
      case (offset_q)
         `OFS_DIFF_REF_EN:    rd_byte = reg0_q;
         `OFS_SPREAD_MISC_EN: rd_byte = reg1_q;
         `OFS_PCI_EN:         rd_byte = reg2_q;
         default:             rd_byte = 8'h00;
      endcase
   end

   // Serial protocol engine
   always @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         state_q     <= ST_IDLE;
         shift_q     <= 8'h00;
         bit_cnt_q   <= 4'h0;
         ack_drive_q <= 1'b0;
         after_ack_q <= 1'b0;
         cmd_seen_q  <= 1'b0;
         is_read_q   <= 1'b0;
         offset_q    <= 7'h00;
         offset_ok_q <= 1'b0;
         wr_pend_q   <= 1'b0;
         wr_data_q   <= 8'h00;
         sda_out     <= 1'b0;
         sda_oe_out  <= 1'b0;
      end else begin
         wr_pend_q <= 1'b0;
         if (start_det) begin
            state_q     <= ST_ADDR; // [RULE1] [RULE3]
            bit_cnt_q   <= 4'h0;
            sda_oe_out  <= 1'b0;
            after_ack_q <= 1'b0;
         end else if (stop_det) begin
            state_q    <= ST_IDLE;
            cmd_seen_q <= 1'b0;
            sda_oe_out <= 1'b0;
         end else begin
            case (state_q)
               ST_IDLE: begin
                  sda_oe_out <= 1'b0;
               end
               ST_ADDR, ST_CMD, ST_WDATA: begin
                  if (scl_rise) begin
                     shift_q   <= byte_in;
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                  end else if (scl_fall && bit_cnt_q == 4'h8) begin
                     bit_cnt_q <= 4'h0;
                     if (state_q == ST_ADDR) begin
                        if (shift_q[7:1] == `SLAVE_ADDR_7 &&
                            (!shift_q[0] || cmd_seen_q)) begin // [RULE10]
                           is_read_q  <= shift_q[0];
                           sda_out    <= 1'b0;
                           sda_oe_out <= 1'b1;
                           state_q    <= ST_AACK;
                        end else begin
                           state_q <= ST_IDLE;
                        end
                     end else if (state_q == ST_CMD) begin
                        if (shift_q[7:5] == `CMD_BYTE_OP_MASK) begin // [RULE2]
                           offset_q    <= shift_q[6:0];
                           offset_ok_q <= shift_q[6:0] <= `OFS_PCI_EN;
                           cmd_seen_q  <= 1'b1;
                           sda_out     <= 1'b0;
                           sda_oe_out  <= 1'b1;
                           state_q     <= ST_AACK;
                        end else begin
                           state_q <= ST_IDLE; // Block access not served
                        end
                     end else begin
                        wr_data_q   <= shift_q;
                        sda_out     <= 1'b0;
                        sda_oe_out  <= 1'b1;
                        after_ack_q <= 1'b1;
                        state_q     <= ST_AACK;
                     end
                  end
               end
               ST_AACK: begin
                  if (scl_fall) begin
                     // Release ack, pick next phase
                     sda_oe_out <= 1'b0;
                     if (after_ack_q) begin
                        after_ack_q <= 1'b0;
                        wr_pend_q   <= offset_ok_q; // [RULE11]
                        state_q     <= ST_IDLE;
                     end else if (is_read_q) begin
                        sda_out    <= rd_byte[7]; // [RULE3]
                        sda_oe_out <= ~rd_byte[7];
                        shift_q    <= {rd_byte[6:0], 1'b0};
                        bit_cnt_q  <= 4'h1;
                        is_read_q  <= 1'b0;
                        state_q    <= ST_RDATA;
                     end else if (!cmd_seen_q || ack_drive_q) begin
                        state_q     <= ST_CMD;
                        ack_drive_q <= 1'b0;
                     end else begin
                        state_q <= ST_WDATA; // [RULE1]
                     end
                     if (!after_ack_q && !is_read_q && !cmd_seen_q) begin
                        ack_drive_q <= 1'b0;
                     end
                  end
               end
               ST_RDATA: begin
                  if (scl_fall) begin
                     if (bit_cnt_q == 4'h8) begin
                        sda_oe_out <= 1'b0;
                        bit_cnt_q  <= 4'h0;
                        state_q    <= ST_MACK;
                     end else begin
                        sda_out    <= shift_q[7];
                        sda_oe_out <= ~shift_q[7]; // Open drain: pull low only
                        shift_q    <= {shift_q[6:0], 1'b0};
                        bit_cnt_q  <= bit_cnt_q + 4'h1;
                     end
                  end
               end
               ST_MACK: begin
                  if (scl_rise) begin
                     state_q <= ST_IDLE; // [RULE3]
                  end
               end
               default: begin
                  state_q <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // Control bytes, power-up defaults
   always @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         reg0_q <= `RST_DIFF_REF_EN; // [RULE4]
         reg1_q <= `RST_SPREAD_MISC_EN; // [RULE5] [RULE6]
         reg2_q <= `RST_PCI_EN; // [RULE9]
      end else if (wr_pend_q) begin
         case (offset_q)
            `OFS_DIFF_REF_EN:    reg0_q <= wr_data_q; // [RULE11]
            `OFS_SPREAD_MISC_EN: reg1_q <= wr_data_q;
            `OFS_PCI_EN:         reg2_q <= wr_data_q;
            default:             reg0_q <= reg0_q;
         endcase
      end
   end

   // Outputs from flops
   always @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         diff_ref_pair_en_out   <= `RST_DIFF_REF_EN;
         spread_down_mode_out   <= 1'b1;
         dot_clock_pair_en_out  <= 1'b1;
         usb_clock_en_out       <= 1'b1;
         ref_clock_out_0_en_out <= 1'b1;
         ref_clock_out_1_en_out <= 1'b1;
         cpu_pair_1_en_out      <= 1'b1;
         cpu_pair_0_en_out      <= 1'b1;
         spread_on_out          <= 1'b0;
         bus_clock_en_out       <= 6'h3f;
         free_bus_clock_en_out  <= 2'h3;
      end else begin
         diff_ref_pair_en_out   <= reg0_q; // [RULE4]
         spread_down_mode_out   <= reg1_q[`BIT_SPREAD_MODE]; // [RULE5]
         dot_clock_pair_en_out  <= reg1_q[`BIT_DOT_EN]; // [RULE7]
         usb_clock_en_out       <= reg1_q[`BIT_USB_EN]; // [RULE8]
         ref_clock_out_0_en_out <= reg1_q[`BIT_REF_CLOCK_OUT_0_EN]; // [RULE8]
         ref_clock_out_1_en_out <= reg1_q[`BIT_REF_CLOCK_OUT_1_EN]; // [RULE8]
         cpu_pair_1_en_out      <= reg1_q[`BIT_CPU1_EN]; // [RULE7]
         cpu_pair_0_en_out      <= reg1_q[`BIT_CPU0_EN]; // [RULE7]
         spread_on_out          <= reg1_q[`BIT_SPREAD_ON]; // [RULE6]
         bus_clock_en_out       <= reg2_q[7:2]; // [RULE9]
         free_bus_clock_en_out  <= reg2_q[1:0]; // [RULE9]
      end
   end
endmodule

// *** core/line_edge.v ***
// Edge finder for a synchronised serial line
`timescale 1ns/1ps
module line_edge (
   input  wire sys_clk_in,
   input  wire rst_n_in,
   input  wire line_in,
   output wire rise_out,
   output wire fall_out
);
   reg prev_q;

   // Hold last value
   always @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         prev_q <= 1'b1;
      end else begin
         prev_q <= line_in;
      end
   end

   assign rise_out = line_in & ~prev_q;
   assign fall_out = ~line_in & prev_q;
endmodule

// *** core/pin_sync.v ***
// Two-flop synchroniser for one asynchronous input
`timescale 1ns/1ps
module pin_sync #(
   parameter RST_VAL = 1'b1
) (
   input  wire sys_clk_in,
   input  wire rst_n_in,
   input  wire async_in,
   output reg  sync_out
);
   reg meta_q;

   // First stage read only by second stage
   always @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         meta_q   <= RST_VAL;
         sync_out <= RST_VAL;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// *** dv/clk_ctrl_regs_sva.sv ***
// Port checker for the serial control register bank
`timescale 1ns/1ps
module clk_ctrl_regs_sva (
   input logic       sys_clk_in,
   input logic       rst_n_in,
   input logic       scl_in,
   input logic       sda_out,
   input logic       sda_oe_out,
   input logic [7:0] diff_ref_pair_en_out,
   input logic       dot_clock_pair_en_out,
   input logic       usb_clock_en_out,
   input logic       ref_clock_out_0_en_out,
   input logic       ref_clock_out_1_en_out,
   input logic       cpu_pair_1_en_out,
   input logic       cpu_pair_0_en_out,
   input logic       spread_down_mode_out,
   input logic       spread_on_out,
   input logic [5:0] bus_clock_en_out,
   input logic [1:0] free_bus_clock_en_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   logic [7:0] b1;
   logic [7:0] b2;
   logic [3:0] quiet_q;
   // Bytes 1 and 2 rebuilt from the pins
   assign b1 = {spread_down_mode_out, dot_clock_pair_en_out, usb_clock_en_out,
      ref_clock_out_0_en_out, ref_clock_out_1_en_out, cpu_pair_1_en_out,
      cpu_pair_0_en_out, spread_on_out};
   assign b2 = {bus_clock_en_out, free_bus_clock_en_out};
   // Cycles since the device last pulled the line
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in || sda_oe_out)
         quiet_q <= rst_n_in ? 4'h0 : 4'hf;
      else if (quiet_q != 4'hf)
         quiet_q <= quiet_q + 4'h1;
   end
   sequence ack_begins;
      $rose(sda_oe_out);
   endsequence
   rst_byte0_a: assert property ($rose(rst_n_in) |-> diff_ref_pair_en_out == 8'hff)
      else $error("byte 0 pins wrong after reset");
   rst_byte1_a: assert property ($rose(rst_n_in) |-> b1 == 8'hfe)
      else $error("byte 1 pins wrong after reset");
   rst_byte2_a: assert property ($rose(rst_n_in) |-> b2 == 8'hff)
      else $error("byte 2 pins wrong after reset");
   rst_idle_a: assert property ($rose(rst_n_in) |-> !sda_oe_out)
      else $error("data line pulled after reset");
   pull_only_a: assert property (sda_oe_out |-> !sda_out)
      else $error("data line driven high");
   data_edge_a: assert property (!$stable(sda_oe_out) |-> !scl_in)
      else $error("data line moved while clock high");
   ack_hold_a: assert property (ack_begins |-> sda_oe_out [*5])
      else $error("pull on data line too short");
   late_update_a: assert property (!$stable({diff_ref_pair_en_out, b1, b2}) |-> quiet_q <= 4'h4)
      else $error("control pins changed away from an ack");
endmodule
bind clock_output_serial_ctrl_regs clk_ctrl_regs_sva i_sva (.sys_clk_in, .rst_n_in,
   .scl_in, .sda_out, .sda_oe_out, .diff_ref_pair_en_out, .dot_clock_pair_en_out,
   .usb_clock_en_out, .ref_clock_out_0_en_out, .ref_clock_out_1_en_out, .cpu_pair_1_en_out,
   .cpu_pair_0_en_out, .spread_down_mode_out, .spread_on_out, .bus_clock_en_out,
   .free_bus_clock_en_out);

// *** dv/serial_host_model.sv ***
// Bus master model for the two-wire link, clock period 125 ns
`timescale 1ns/1ps
module serial_host_model (
   input  logic sda_in,
   output logic scl_out,
   output logic sda_pull_out
);
   localparam realtime Q = 31.25;
   // Idle: clock high, line released to its pull-up
   initial begin
      scl_out = 1'b1;
      sda_pull_out = 1'b0;
   end
   // One bit slot, data moves only while the clock is low
   task automatic bit_io(input logic tx, output logic rx);
      sda_pull_out = !tx;
      #Q scl_out = 1'b1;
      #Q rx = sda_in;
      #Q scl_out = 1'b0;
      #Q;
   endtask
   // Eight bits MSB first, then the ninth slot for the ack
   task automatic byte_io(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                          output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], b);
         rx[i] = b;
      end
      bit_io(mack, b);
      ack = !b;
   endtask
   // Byte write or byte read, optionally cut short after the command
   task automatic xfer(input logic [7:0] adr, input logic [7:0] cmd, input logic [7:0] dat,
                       input logic rd, input logic cut, output logic [7:0] q,
                       output logic [2:0] acks);
      logic [7:0] junk;
      logic       nb;
      sda_pull_out = 1'b1;
      #Q scl_out = 1'b0;
      #Q;
      byte_io(adr, 1'b1, junk, acks[2]);
      byte_io(cmd, 1'b1, junk, acks[1]);
      acks[0] = 1'b0;
      q = 8'h00;
      if (rd && !cut) begin
         sda_pull_out = 1'b0;
         #Q scl_out = 1'b1;
         #Q sda_pull_out = 1'b1;
         #Q scl_out = 1'b0;
         #Q;
         byte_io(adr | 8'h01, 1'b1, junk, acks[0]);
         byte_io(8'hff, 1'b0, q, nb);
      end
      else if (!cut)
         byte_io(dat, 1'b1, junk, acks[0]);
      sda_pull_out = 1'b1;
      #Q scl_out = 1'b1;
      #Q sda_pull_out = 1'b0;
      #(4*Q);
   endtask
endmodule

// *** dv/tb.sv ***
// Testbench for the serial control register bank
`timescale 1ns/1ps
module tb;
   logic        sys_clk_in;
   logic        rst_n_in;
   logic        scl;
   logic        pull;
   logic        sda_o;
   logic        sda_oe;
   logic        line;
   logic [23:0] pins;
   logic [7:0]  q;
   logic [2:0]  a;
   logic [7:0]  mdl [3];
   logic [1:0]  wo [4] = '{2'h0, 2'h1, 2'h1, 2'h2};
   logic [7:0]  wp [4] = '{8'h5a, 8'h81, 8'h7e, 8'h96};
   logic [7:0]  ra [5] = '{8'hd4, 8'hd2, 8'hd2, 8'hd2, 8'hd2};
   logic [7:0]  rc [5] = '{8'h80, 8'h01, 8'ha0, 8'h85, 8'h82};
   logic [2:0]  rk [5] = '{3'h0, 3'h4, 3'h4, 3'h7, 3'h6};
   int          errors = 0;
   int          num_checks = 0;
   // Open-drain line with pull-up
   assign line = !(pull || (sda_oe && !sda_o));
   serial_host_model i_host (.sda_in(line), .scl_out(scl), .sda_pull_out(pull));
   clock_output_serial_ctrl_regs i_dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
      .scl_in(scl), .sda_in(line), .sda_out(sda_o), .sda_oe_out(sda_oe),
      .diff_ref_pair_en_out(pins[23:16]), .spread_down_mode_out(pins[15]),
      .dot_clock_pair_en_out(pins[14]), .usb_clock_en_out(pins[13]),
      .ref_clock_out_0_en_out(pins[12]), .ref_clock_out_1_en_out(pins[11]),
      .cpu_pair_1_en_out(pins[10]), .cpu_pair_0_en_out(pins[9]), .spread_on_out(pins[8]),
      .bus_clock_en_out(pins[7:2]), .free_bus_clock_en_out(pins[1:0]));
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Reset pulse driven on the falling edge, power-up values checked
   task automatic do_reset(input int n);
      @(negedge sys_clk_in);
      rst_n_in = 1'b0;
      repeat (n) @(negedge sys_clk_in);
      rst_n_in = 1'b1;
      repeat (8) @(negedge sys_clk_in);
      mdl = '{8'hff, 8'hfe, 8'hff};
      check(pins, 24'hfffeff);
      for (int i = 0; i < 3; i++) begin
         i_host.xfer(8'hd2, 8'h80 | 8'(i), 8'h00, 1'b1, 1'b0, q, a);
         check({13'h0, a, q}, {13'h0, 3'h7, mdl[i]});
      end
      $display("reset test done");
   endtask
   initial begin
      sys_clk_in = 1'b0;
      forever #5 sys_clk_in = !sys_clk_in;
   end
   initial begin
      #500us;
      errors++;
      print_verdict();
   end
   initial begin
      do_reset(12);
      // Writes land on the pins and read back
      for (int i = 0; i < 4; i++) begin
         i_host.xfer(8'hd2, {6'h20, wo[i]}, wp[i], 1'b0, 1'b0, q, a);
         mdl[wo[i]] = wp[i];
         check({21'h0, a}, 24'h7);
         check(pins, {mdl[0], mdl[1], mdl[2]});
         i_host.xfer(8'hd2, {6'h20, wo[i]}, 8'h00, 1'b1, 1'b0, q, a);
         check({13'h0, a, q}, {13'h0, 3'h7, wp[i]});
      end
      $display("write test done");
      // Wrong address, bad commands, unmapped offset, early stop
      for (int i = 0; i < 5; i++) begin
         i_host.xfer(ra[i], rc[i], 8'h00, 1'b0, i == 4, q, a);
         check({21'h0, a}, {21'h0, rk[i]});
         check(pins, {mdl[0], mdl[1], mdl[2]});
      end
      i_host.xfer(8'hd2, 8'h85, 8'h00, 1'b1, 1'b0, q, a);
      check({13'h0, a, q}, {13'h0, 3'h7, 8'h00});
      $display("refusal test done");
      do_reset(2);
      print_verdict();
   end
endmodule
